// ==== core/rbd_pkg.sv ====
// Purpose: shared constants, layouts and helpers of the ram board bus decode block
// Assumes: 200 MHz clock, AXI4-Lite with 32-bit data for configuration
// Notes: configuration words stand in for the board straps
package rbd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_PORT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam logic [7:0] REG_PFLAG = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // configuration layouts and reset values
  // ----------------------------------------------------------------
  // cfg word: [3:0] page, [11:4] base in 4k blocks, [12] advanced write,
  // [15:13] board variant, [16] parity flag disable
  typedef struct packed {
    logic parity_off;
    logic [2:0] variant;
    logic adv_write;
    logic [7:0] base_4k;
    logic [3:0] page;
  } rbd_cfg_s;
  localparam int CFG_W = 17;
  localparam logic [16:0] CFG_RST = 17'h00000;

  // port word: [0] low byte enable, [1] lines 8-11, [2] lines 12-15,
  // [3] line 6 must be high, [7:4] lines 3..0 must be low when set
  typedef struct packed {
    logic [3:0] low_fitted;
    logic adr6_high;
    logic en_high;
    logic en_mid;
    logic en_low;
  } rbd_port_s;
  localparam int PORT_W = 8;
  localparam logic [7:0] PORT_RST = 8'h07;

  // board variants, smallest first
  localparam logic [2:0] VAR_16K = 3'h0;
  localparam logic [2:0] VAR_32K = 3'h1;
  localparam logic [2:0] VAR_64K = 3'h2;
  localparam logic [2:0] VAR_128K = 3'h3;

  // parity flag register and interrupt events
  localparam int PF_W = 3;
  localparam int PF_ERR0 = 0;
  localparam int PF_ERR1 = 1;
  localparam int PF_TYPE = 2;
  localparam int IOW_TYPE = 0;
  localparam int EV_W = 3;
  localparam int EV_PARITY = 0;
  localparam int EV_IOCLR = 1;
  localparam int EV_WRITE = 2;
  localparam logic [2:0] EV_RST = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int ADV_WRITE_NS = 500;
  localparam int ADV_WRITE_CY = (ADV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {WR_IDLE, WR_WAIT, WR_HOLD} rbd_wr_e;

  // captured write towards the two paired byte banks
  typedef struct packed {
    logic bank0_en;
    logic bank1_en;
    logic [7:0] bank0_data;
    logic [7:0] bank1_data;
  } rbd_wr_s;

  // board capacity in bytes, 21 bits so a window can reach past the page
  function automatic logic [20:0] rbd_cap_bytes(input logic [2:0] v);
    case (v)
      VAR_16K: rbd_cap_bytes = 21'h004000;
      VAR_32K: rbd_cap_bytes = 21'h008000;
      VAR_64K: rbd_cap_bytes = 21'h010000;
      VAR_128K: rbd_cap_bytes = 21'h020000;
      default: rbd_cap_bytes = 21'h040000;
    endcase
  endfunction

  // byte-lane merge of a register write
  function automatic logic [31:0] rbd_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      rbd_merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

endpackage

// ==== core/rbd_port_decode.sv ====
// Purpose: i/o port match for the parity flag register
// Assumes: address lines in positive logic, 1 = line active
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module rbd_port_decode (
  // address and strap set
  input wire logic [15:0] addr_i,
  input wire rbd_pkg::rbd_port_s port_i,
  // result
  output logic match_o
);

  logic low_ok;
  logic mid_ok;
  logic high_ok;

  // low byte: line 6 polarity, lines 0-3 polarity, rest of the byte inactive
  assign low_ok = !port_i.en_low || ((addr_i[6] == port_i.adr6_high) &&
                  (addr_i[3:0] == ~port_i.low_fitted) &&
                  (addr_i[7] == 1'b0) && (addr_i[5:4] == 2'h0));
  // upper groups only count while strapped in
  assign mid_ok = !port_i.en_mid || (addr_i[11:8] == 4'h0);
  assign high_ok = !port_i.en_high || (addr_i[15:12] == 4'h0);
  assign match_o = low_ok && mid_ok && high_ok;

endmodule
`default_nettype wire

// ==== core/rbd_top.sv ====
// Purpose: memory window decode, write qualification and parity flag port of a ram board
// Assumes: bus command and address inputs synchronous to clk_i; software sets the straps
// Notes: one write and one read under way at a time on the register bus
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - banks 0/1 pair; odd byte to bank 0
// - page straps compared with top four bits
// - base straps count 4k blocks from zero
// - default delayed mode captures on command
// - advanced mode waits 500 ns for data
// - default straps answer port 000F
// - decode over 8, 12 or 16 bits
// - line 6 low by default, else high
// - lines 0-3 high unless polarity strap fitted
// - smallest variant may disable parity flag
// - port read returns flags; write clears them
// - no address carried past page boundary
module rbd_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // axi4-lite write channels
  input wire logic [rbd_pkg::AXI_AW-1:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // axi4-lite read channels
  input wire logic [rbd_pkg::AXI_AW-1:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // system bus memory side
  input wire logic [23:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic mem_word_i,
  input wire logic [15:0] mem_wdata_i,
  output logic mem_select_o,
  output rbd_pkg::rbd_wr_s wr_o,
  output logic wr_strobe_o,
  // system bus i/o side
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic io_port_select_o,
  output logic [7:0] io_rdata_o,
  // parity check and generate
  input wire logic [1:0] parity_err_i,
  output logic parity_type_o,
  // interrupt
  output logic irq_o
);

  localparam int ADV_CY = rbd_pkg::ADV_WRITE_CY;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rbd_pkg::rbd_cfg_s cfg;
  rbd_pkg::rbd_port_s port;
  logic [rbd_pkg::EV_W-1:0] status;
  logic [rbd_pkg::EV_W-1:0] mask;
  logic [rbd_pkg::EV_W-1:0] events;
  logic [rbd_pkg::PF_W-1:0] pflag;
  logic aw_full;
  logic w_full;
  logic [rbd_pkg::AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic next_aw_full;
  logic next_w_full;
  logic next_rvalid;
  logic ar_hs;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [20:0] win_lo;
  logic [20:0] win_hi;
  logic page_hit;
  logic mem_hit;
  logic port_hit;
  logic adv_eff;
  logic rec_parity;
  logic wr_q;
  logic wr_rise;
  logic cap_now;
  logic lat_word;
  logic lat_a0;
  logic [7:0] cnt;
  rbd_pkg::rbd_wr_e wr_state;

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  // a write fires once both halves are held and no response is pending
  assign do_write = aw_full && w_full && !s_bvalid_o;
  assign next_aw_full = do_write ? 1'b0 : (aw_full || (s_awvalid_i && s_awready_o));
  assign next_w_full = do_write ? 1'b0 : (w_full || (s_wvalid_i && s_wready_o));
  assign ar_hs = s_arvalid_i && s_arready_o;
  assign next_rvalid = ar_hs || (s_rvalid_o && !s_rready_i);

  // address and data are taken in either order
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_awready_o <= 1'b0;
      s_wready_o <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_awready_o <= !next_aw_full;
      s_wready_o <= !next_w_full;
      if (s_awvalid_i && s_awready_o) awaddr_q <= s_awaddr_i;
      if (s_wvalid_i && s_wready_o) begin
        wdata_q <= s_wdata_i;
        wstrb_q <= s_wstrb_i;
      end
    end
  end

  // write response, slverr for an unmapped or read-only word
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_bvalid_o <= 1'b0;
      s_bresp_o <= rbd_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_bvalid_o <= 1'b1;
      s_bresp_o <= (awaddr_q == rbd_pkg::REG_CFG || awaddr_q == rbd_pkg::REG_PORT ||
                    awaddr_q == rbd_pkg::REG_MASK) ? rbd_pkg::RESP_OKAY : rbd_pkg::RESP_SLVERR;
    end else if (s_bready_i) begin
      s_bvalid_o <= 1'b0;
    end
  end

  // software-written straps and mask
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cfg <= rbd_pkg::rbd_cfg_s'(rbd_pkg::CFG_RST);
      port <= rbd_pkg::rbd_port_s'(rbd_pkg::PORT_RST);
      mask <= rbd_pkg::EV_RST;
    end else if (do_write) begin
      unique case (awaddr_q)
        rbd_pkg::REG_CFG: cfg <= rbd_pkg::rbd_cfg_s'(
            rbd_pkg::rbd_merge(32'(cfg), wdata_q, wstrb_q)
        );
        rbd_pkg::REG_PORT: port <= rbd_pkg::rbd_port_s'(
            rbd_pkg::rbd_merge(32'(port), wdata_q, wstrb_q)
        );
        rbd_pkg::REG_MASK: mask <= rbd_pkg::EV_W'(
            rbd_pkg::rbd_merge(32'(mask), wdata_q, wstrb_q)
        );
        default: ;
      endcase
    end
  end

  // read word selection
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    case (s_araddr_i)
      rbd_pkg::REG_CFG: rd_word = 32'(cfg);
      rbd_pkg::REG_PORT: rd_word = 32'(port);
      rbd_pkg::REG_STATUS: rd_word = 32'(status);
      rbd_pkg::REG_MASK: rd_word = 32'(mask);
      rbd_pkg::REG_PFLAG: rd_word = 32'(pflag);
      default: rd_ok = 1'b0;
    endcase
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_rvalid_o <= 1'b0;
      s_arready_o <= 1'b0;
      s_rdata_o <= 32'h00000000;
      s_rresp_o <= rbd_pkg::RESP_OKAY;
    end else begin
      s_rvalid_o <= next_rvalid;
      s_arready_o <= !next_rvalid;
      if (ar_hs) begin
        s_rdata_o <= rd_word;
        s_rresp_o <= rd_ok ? rbd_pkg::RESP_OKAY : rbd_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  assign events[rbd_pkg::EV_PARITY] = rec_parity && (parity_err_i != 2'h0);
  assign events[rbd_pkg::EV_IOCLR] = io_wr_i && port_hit;
  assign events[rbd_pkg::EV_WRITE] = cap_now;

  // read clears, but an event in the same cycle survives
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      status <= rbd_pkg::EV_RST;
    end else if (ar_hs && s_araddr_i == rbd_pkg::REG_STATUS) begin
      status <= events;
    end else begin
      status <= status | events;
    end
  end

  // level output, one cycle behind the status bits
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) irq_o <= 1'b0;
    else irq_o <= |(status & mask);
  end

  // ----------------------------------------------------------------
  // memory window decode
  // ----------------------------------------------------------------
  // window kept 21 bits wide: the part past the page never compares
  assign win_lo = {1'b0, cfg.base_4k, 12'h000};
  assign win_hi = win_lo + rbd_pkg::rbd_cap_bytes(cfg.variant);
  assign page_hit = (mem_addr_i[23:20] == cfg.page);
  assign mem_hit = page_hit && ({1'b0, mem_addr_i[19:0]} >= win_lo) &&
                   ({1'b0, mem_addr_i[19:0]} < win_hi);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) mem_select_o <= 1'b0;
    else mem_select_o <= (mem_rd_i || mem_wr_i) && mem_hit;
  end

  // ----------------------------------------------------------------
  // write qualification
  // ----------------------------------------------------------------
  // advanced mode exists only on the mid-capacity variant
  assign adv_eff = cfg.adv_write && (cfg.variant == rbd_pkg::VAR_64K);
  assign wr_rise = mem_wr_i && !wr_q;
  assign cap_now = (wr_state == rbd_pkg::WR_IDLE && wr_rise && mem_hit && !adv_eff) ||
                   (wr_state == rbd_pkg::WR_WAIT && cnt == 8'(ADV_CY - 1));

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) wr_q <= 1'b0;
    else wr_q <= mem_wr_i;
  end

  // command edge starts a capture; advanced mode counts out the data delay
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_state <= rbd_pkg::WR_IDLE;
      cnt <= 8'h00;
      lat_word <= 1'b0;
      lat_a0 <= 1'b0;
    end else begin
      unique case (wr_state)
        rbd_pkg::WR_IDLE: begin
          lat_word <= mem_word_i;
          lat_a0 <= mem_addr_i[0];
          cnt <= 8'h01;
          if (wr_rise && mem_hit) begin
            wr_state <= adv_eff ? rbd_pkg::WR_WAIT : rbd_pkg::WR_HOLD;
          end
        end
        rbd_pkg::WR_WAIT: begin
          cnt <= cnt + 8'h01;
          if (cap_now) wr_state <= rbd_pkg::WR_HOLD;
        end
        rbd_pkg::WR_HOLD: begin
          if (!mem_wr_i) wr_state <= rbd_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // byte steering: a word fills both banks, odd byte into bank 0
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_strobe_o <= 1'b0;
      wr_o <= '0;
    end else begin
      wr_strobe_o <= cap_now;
      if (cap_now) begin
        wr_o.bank0_en <= (wr_state == rbd_pkg::WR_IDLE) ? (mem_word_i || mem_addr_i[0])
                                                         : (lat_word || lat_a0);
        wr_o.bank1_en <= (wr_state == rbd_pkg::WR_IDLE) ? (mem_word_i || !mem_addr_i[0])
                                                         : (lat_word || !lat_a0);
        wr_o.bank0_data <= ((wr_state == rbd_pkg::WR_IDLE) ? mem_word_i : lat_word) ?
                           mem_wdata_i[15:8] : mem_wdata_i[7:0];
        wr_o.bank1_data <= mem_wdata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // parity flag port
  // ----------------------------------------------------------------
  rbd_port_decode u_port_decode (
    .addr_i(io_addr_i),
    .port_i(port),
    .match_o(port_hit)
  );

  // the smallest board can switch the flag off entirely
  assign rec_parity = !(cfg.parity_off && cfg.variant == rbd_pkg::VAR_16K);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      io_port_select_o <= 1'b0;
      io_rdata_o <= 8'h00;
    end else begin
      io_port_select_o <= (io_rd_i || io_wr_i) && port_hit;
      io_rdata_o <= (io_rd_i && port_hit) ? 8'(pflag) : 8'h00;
    end
  end

  // write clears the error bits and loads the parity type; new errors win
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pflag <= '0;
    end else if (io_wr_i && port_hit) begin
      pflag[rbd_pkg::PF_ERR1:rbd_pkg::PF_ERR0] <= parity_err_i & {2{rec_parity}};
      pflag[rbd_pkg::PF_TYPE] <= io_wdata_i[rbd_pkg::IOW_TYPE];
    end else begin
      pflag[rbd_pkg::PF_ERR1:rbd_pkg::PF_ERR0] <= pflag[rbd_pkg::PF_ERR1:rbd_pkg::PF_ERR0] |
                                                  (parity_err_i & {2{rec_parity}});
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) parity_type_o <= 1'b0;
    else parity_type_o <= pflag[rbd_pkg::PF_TYPE];
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_bank_pair;
    wr_strobe_o && $past(wr_state == rbd_pkg::WR_IDLE) && $past(mem_word_i) |->
      wr_o.bank0_en && wr_o.bank1_en && wr_o.bank0_data == $past(mem_wdata_i[15:8]);
  endproperty
  a_bank_pair: assert property (p_bank_pair) else $error("word write not split over bank pair");

  property p_page;
    mem_select_o |-> $past(mem_addr_i[23:20]) == $past(cfg.page);
  endproperty
  a_page: assert property (p_page) else $error("select outside strapped page");

  property p_window;
    mem_select_o |-> {1'b0, $past(mem_addr_i[19:0])} >= $past(win_lo) &&
                     {1'b0, $past(mem_addr_i[19:0])} < $past(win_hi);
  endproperty
  a_window: assert property (p_window) else $error("select outside memory window");

  property p_delayed;
    wr_state == rbd_pkg::WR_IDLE && wr_rise && mem_hit && !adv_eff |=> wr_strobe_o;
  endproperty
  a_delayed: assert property (p_delayed) else $error("delayed write not captured on command");

  sequence s_adv_start;
    wr_state == rbd_pkg::WR_IDLE && wr_rise && mem_hit && adv_eff;
  endsequence
  property p_adv;
    s_adv_start |-> ##1 (!wr_strobe_o)[*8] ##(ADV_CY - 8) wr_strobe_o;
  endproperty
  a_adv: assert property (p_adv) else $error("advanced write capture not delayed");

  property p_port_default;
    io_rd_i && io_addr_i == 16'h000F && port == rbd_pkg::rbd_port_s'(rbd_pkg::PORT_RST) |=>
      io_port_select_o && io_rdata_o == 8'($past(pflag));
  endproperty
  a_port_default: assert property (p_port_default) else $error("default port not answered");

  property p_port_gate;
    io_port_select_o |-> $past(io_rd_i || io_wr_i) &&
      (!$past(port.en_low) || $past(io_addr_i[3:0]) == ~$past(port.low_fitted));
  endproperty
  a_port_gate: assert property (p_port_gate) else $error("port select without match");

  property p_adr6;
    io_port_select_o && $past(port.en_low) |-> $past(io_addr_i[6]) == $past(port.adr6_high);
  endproperty
  a_adr6: assert property (p_adr6) else $error("port select with wrong line 6");

  property p_parity_off;
    !rec_parity && pflag[1:0] == 2'h0 |=> pflag[1:0] == 2'h0;
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("flag set while disabled");

  property p_io_clear;
    io_wr_i && port_hit && parity_err_i == 2'h0 |=> pflag[1:0] == 2'h0 && pflag[2] == $past(io_wdata_i[0]);
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("port write did not clear flags");

  c_adv: cover property (s_adv_start ##ADV_CY wr_strobe_o);
  c_word: cover property (wr_strobe_o && wr_o.bank0_en && wr_o.bank1_en);
  c_port: cover property (io_wr_i && port_hit ##1 io_port_select_o);
  c_irq: cover property (irq_o);

endmodule
`default_nettype wire

// ==== test/rbd_bus_master.sv ====
// Purpose: system bus master model facing the ram board decode
// Assumes: active-high commands, one command at a time
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module rbd_bus_master (
  // clock
  input wire logic clk_i,
  // memory commands
  output logic [23:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_word_o,
  output logic [15:0] mem_wdata_o,
  // i/o commands
  output logic [15:0] io_addr_o,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic [7:0] io_wdata_o
);
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  initial begin
    {mem_addr_o, mem_rd_o, mem_wr_o, mem_word_o, mem_wdata_o} = '0;
    {io_addr_o, io_rd_o, io_wr_o, io_wdata_o} = '0;
  end
  // drop commands; inverted lines keep a stale value from passing as a hold
  task automatic idle();
    @(posedge clk_i);
    {mem_rd_o, mem_wr_o, io_rd_o, io_wr_o} <= 4'h0;
    mem_addr_o <= ~mem_addr_o;
    mem_wdata_o <= ~mem_wdata_o;
    io_wdata_o <= ~io_wdata_o;
    io_addr_o <= ~io_addr_o;
    #1;
  endtask
  // returns just after the edge that takes the command
  task automatic mem_read(input logic [23:0] a);
    @(posedge clk_i);
    mem_addr_o <= a;
    mem_rd_o <= 1'b1;
    @(posedge clk_i);
    #1;
  endtask
  task automatic io_cmd(input logic [15:0] a, input logic wr, input logic [7:0] d);
    @(posedge clk_i);
    io_addr_o <= a; // undecoded lines given as zero
    io_wdata_o <= d;
    io_rd_o <= !wr;
    io_wr_o <= wr;
    @(posedge clk_i);
    #1;
  endtask
  // returns with the write command still held
  task automatic mem_write(input logic [23:0] a, input logic w, input logic [15:0] d, input logic adv);
    @(posedge clk_i);
    mem_addr_o <= a;
    mem_word_o <= w;
    mem_wdata_o <= adv ? ~d : d;
    if (!adv) repeat (10) @(posedge clk_i); // data 50 ns ahead
    mem_wr_o <= 1'b1;
    if (adv) begin
      repeat (90) @(posedge clk_i); // data 450 ns after command
      mem_wdata_o <= d;
    end
  endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: self-checking bench of the ram board decode
// Assumes: 200 MHz clock, registers reached over axi4-lite
// Notes: select rows in a table, writes and parity flag by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic io; logic [16:0] cfg; logic [23:0] addr; logic sel;} rbd_row_s;
  logic clk_i, reset_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
  logic [7:0] s_awaddr_i, s_araddr_i;
  logic [31:0] s_wdata_i, s_rdata_o, d;
  logic [3:0] s_wstrb_i;
  logic [1:0] parity_err_i, s_bresp_o, s_rresp_o, rsp;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, mem_select_o, wr_strobe_o;
  logic io_port_select_o, parity_type_o, irq_o;
  logic [7:0] io_rdata_o;
  rbd_pkg::rbd_wr_s wr_o;
  wire [23:0] mem_addr_i;
  wire [15:0] mem_wdata_i, io_addr_i;
  wire [7:0] io_wdata_i;
  wire mem_rd_i, mem_wr_i, mem_word_i, io_rd_i, io_wr_i;
  int num_errors = 0;
  int n_tests = 0;
  int n;
  // cfg: {off, variant, adv, base, page}; io rows carry the port word
  rbd_row_s rows [19] = '{{1'b0, 17'h00000, 24'h000000, 1'b1}, {1'b0, 17'h00000, 24'h003FFF, 1'b1},
    {1'b0, 17'h00000, 24'h004000, 1'b0}, {1'b0, 17'h02105, 24'h510000, 1'b1},
    {1'b0, 17'h02105, 24'h517FFF, 1'b1}, {1'b0, 17'h02105, 24'h518000, 1'b0},
    {1'b0, 17'h02105, 24'h410000, 1'b0}, {1'b0, 17'h02105, 24'h50FFFF, 1'b0},
    {1'b0, 17'h08C00, 24'h0FFFFF, 1'b1}, {1'b0, 17'h08C00, 24'h100000, 1'b0},
    {1'b1, 17'h00007, 24'h00000F, 1'b1}, {1'b1, 17'h00007, 24'h00001F, 1'b0},
    {1'b1, 17'h00007, 24'h00004F, 1'b0}, {1'b1, 17'h0000F, 24'h00004F, 1'b1},
    {1'b1, 17'h000F7, 24'h000000, 1'b1}, {1'b1, 17'h000F7, 24'h00000F, 1'b0},
    {1'b1, 17'h00006, 24'h000000, 1'b1}, {1'b1, 17'h00007, 24'h000F0F, 1'b0},
    {1'b1, 17'h00003, 24'h00010F, 1'b0}};
  rbd_bus_master bus (.clk_i, .mem_addr_o(mem_addr_i), .mem_rd_o(mem_rd_i), .mem_wr_o(mem_wr_i),
    .mem_word_o(mem_word_i), .mem_wdata_o(mem_wdata_i), .io_addr_o(io_addr_i), .io_rd_o(io_rd_i),
    .io_wr_o(io_wr_i), .io_wdata_o(io_wdata_i));
  rbd_top dut (.clk_i, .reset_n_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i,
    .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i,
    .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .mem_addr_i, .mem_rd_i, .mem_wr_i,
    .mem_word_i, .mem_wdata_i, .mem_select_o, .wr_o, .wr_strobe_o, .io_addr_i, .io_rd_i, .io_wr_i,
    .io_wdata_i, .io_port_select_o, .io_rdata_o, .parity_err_i, .parity_type_o, .irq_o);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge clk_i);
    {s_awaddr_i, s_wdata_i} <= {a, v};
    {s_awvalid_i, s_wvalid_i, s_bready_i} <= 3'h7;
    do begin
      @(posedge clk_i);
      if (s_awready_o) s_awvalid_i <= 1'b0;
      if (s_wready_o) s_wvalid_i <= 1'b0;
    end while (s_bvalid_o !== 1'b1);
    r = s_bresp_o;
    s_bready_i <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk_i);
    s_araddr_i <= a;
    {s_arvalid_i, s_rready_i} <= 2'h3;
    do begin
      @(posedge clk_i);
      if (s_arready_o) s_arvalid_i <= 1'b0;
    end while (s_rvalid_o !== 1'b1);
    {v, r} = {s_rdata_o, s_rresp_o};
    s_rready_i <= 1'b0;
  endtask
  task automatic wait_strobe(output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      #1;
      c++;
    end while (wr_strobe_o !== 1'b1 && c < 200);
  endtask
  task automatic pulse_err();
    @(posedge clk_i);
    parity_err_i <= 2'h1;
    @(posedge clk_i);
    parity_err_i <= 2'h0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
  initial begin
    {reset_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = '0;
    {s_awaddr_i, s_araddr_i, s_wdata_i, parity_err_i} = '0;
    s_wstrb_i = 4'hF;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    axi_rd(rbd_pkg::REG_PORT, d, rsp);
    check("port_rst", d, 32'h7);
    axi_rd(8'h14, d, rsp);
    check("unmapped", rsp, rbd_pkg::RESP_SLVERR);
    axi_wr(rbd_pkg::REG_STATUS, 32'h0, rsp);
    check("ro_write", rsp, rbd_pkg::RESP_SLVERR);
    bus.mem_write(24'h000100, 1'b1, 16'hA55A, 1'b0);
    wait_strobe(n);
    check("wr_lat", n, 1);
    check("wr_word", 32'(wr_o), 32'h3A55A);
    bus.idle();
    bus.mem_write(24'h000101, 1'b0, 16'h00C3, 1'b0);
    wait_strobe(n);
    check("wr_odd", 32'(wr_o[17:8]), 32'h2C3);
    bus.idle();
    axi_wr(rbd_pkg::REG_CFG, 32'h1000, rsp);
    bus.mem_write(24'h000102, 1'b1, 16'h0F0F, 1'b0);
    wait_strobe(n);
    check("adv_small", n, 1);
    bus.idle();
    axi_wr(rbd_pkg::REG_CFG, 32'h5000, rsp);
    bus.mem_write(24'h000200, 1'b1, 16'h1234, 1'b1);
    wait_strobe(n);
    check("adv_data", 32'(wr_o), 32'h31234);
    bus.idle();
    $display("test writes done");
    foreach (rows[i]) begin
      axi_wr(rows[i].io ? rbd_pkg::REG_PORT : rbd_pkg::REG_CFG, {15'h0, rows[i].cfg}, rsp);
      if (rows[i].io) bus.io_cmd(rows[i].addr[15:0], 1'b0, 8'h00);
      else bus.mem_read(rows[i].addr);
      check("select", rows[i].io ? io_port_select_o : mem_select_o, rows[i].sel);
      bus.idle();
    end
    $display("test rows done");
    axi_wr(rbd_pkg::REG_PORT, 32'h7, rsp);
    axi_wr(rbd_pkg::REG_CFG, 32'h0, rsp);
    axi_wr(rbd_pkg::REG_MASK, 32'h1, rsp);
    pulse_err();
    check("irq_on", irq_o, 1);
    bus.io_cmd(16'h000F, 1'b0, 8'h00);
    check("flags", io_rdata_o, 8'h01);
    bus.io_cmd(16'h000F, 1'b1, 8'h01);
    bus.idle();
    check("ptype", parity_type_o, 1);
    axi_rd(rbd_pkg::REG_STATUS, d, rsp);
    check("status", d[0], 1);
    bus.io_cmd(16'h000F, 1'b0, 8'h00);
    check("cleared", io_rdata_o, 8'h04);
    check("irq_off", irq_o, 0);
    bus.idle();
    axi_wr(rbd_pkg::REG_CFG, 32'h10000, rsp);
    pulse_err();
    bus.io_cmd(16'h000F, 1'b0, 8'h00);
    check("flag_off", io_rdata_o, 8'h04);
    bus.idle();
    axi_wr(rbd_pkg::REG_CFG, 32'h0, rsp);
    axi_wr(rbd_pkg::REG_MASK, 32'h0, rsp);
    pulse_err();
    check("irq_mask", irq_o, 0);
    $display("test parity done");
    close_out();
  end
endmodule
`default_nettype wire
